// *** logic/sws_defines.svh ***
`ifndef SWS_DEFINES_SVH
`define SWS_DEFINES_SVH
// Timing derived from the 100 MHz system clock
`define SWS_CLK_HZ 100000000
`define SWS_WDOG_TICK_MS 1
`define SWS_MS_CYCLES ((`SWS_CLK_HZ / 1000) * `SWS_WDOG_TICK_MS)
// Supply and transition sequencing
`define SWS_NUM_SUPPLIES 3
`define SWS_SUPPLY_ALL_GOOD 3'h7
`define SWS_TRANS_CYCLES 16'h0010
// Retention memory geometry: 128 bytes
`define SWS_RET_DEPTH 128
`define SWS_RET_AW 7
// Reset values
`define SWS_RTC_RESET 64'h0000000000000000
`define SWS_WDOG_RESET 16'h0000
`define SWS_MS_RESET 17'h00000
`define SWS_TRANS_RESET 16'h0000
// Wake-pin polarity encodings
`define SWS_WAKE_ON_HIGH 1'b1
`endif

// *** logic/sws_pkg.sv ***
package sws_pkg;
   // Power states seen by software
   typedef enum logic [2:0] {
      SWS_ST_POR,
      SWS_ST_AWAKE,
      SWS_ST_TO_SLEEP,
      SWS_ST_ASLEEP,
      SWS_ST_TO_WAKE
   } sws_state_t;

   // Sleep configuration, as software leaves it before requesting sleep
   typedef struct packed {
      logic supplies_off;          // All supplies off except the second buck
      logic pulse_frequency_mode;  // Supplies run in pulse-frequency mode
      logic clock_mask;            // Gate the digital clock
      logic assert_reset;          // Hold digital node in reset while asleep
      logic slow_osc_sel;          // Count from slow oscillator while asleep
      logic wake_pin_en;           // Wake on pin
      logic wake_pin_level;        // Pin level that wakes
      logic wake_timer_en;         // Wake on counter match
   } sws_sleep_cfg_t;

   // Power-domain controls driven out
   typedef struct packed {
      logic digital_pwr_en;
      logic digital_clk_en;
      logic digital_rst_n;
      logic supply_other_en;
      logic second_buck_supply_en;
      logic pulse_frequency_mode;
   } sws_pwr_ctl_t;

   // Retention memory access port
   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] wdata;
   } sws_ret_req_t;
endpackage

// *** logic/sws_retention_mem.sv ***
`timescale 1ns/1ps
`include "sws_defines.svh"
// 128-byte memory on the always-on domain; keeps data through sleep
module sws_retention_mem
(
   input wire logic clk_sys,                 // System clock
   input wire logic aon_alive,               // Always-on domain powered
   input wire sws_pkg::sws_ret_req_t req,    // Access request
   output logic [7:0] rdata                  // Registered read data
);
   import sws_pkg::*;

   logic [7:0] mem [0:`SWS_RET_DEPTH-1];

   // Writes only when powered; contents are undefined after power loss
   always_ff @(posedge clk_sys)
   begin
      if (aon_alive && req.we)
         mem[req.addr] <= req.wdata;
      rdata <= mem[req.addr];
   end
endmodule // sws_retention_mem

// *** logic/sleep_wake_supervisor.sv ***
`timescale 1ns/1ps
`include "sws_defines.svh"
// How it works
// - Wake from sleep on selected pin level
// - Wake from sleep on counter compare match
// - Wake stimuli ignored while running
// - Stimulus during sleep entry is remembered
// - Sleep powers down digital node, and other supplies except second buck if selected
// - Counter increments each main-clock tick awake
// - Counter locked to 100 MHz timer clock
// - Optionally count slow oscillator while asleep
// - Slow tick adds programmable increment
// - 16-bit millisecond watchdog, 1 ms..65 s
// - Watchdog shares no state with counter
// - Unreloaded watchdog expiry resets chip
// - Watchdog reset cause readable after boot
// - Watchdog runs only while awake
// - Hold reset until all supplies good
// - Supply loss resets like cold start
// - Supply loss in transition resets system
// - 128-byte retention memory through sleep
module sleep_wake_supervisor
(
   input wire logic clk_sys,                        // 100 MHz main clock
   input wire logic reset_n,                        // Sync reset, active low
   input wire logic [2:0] supply_good,              // Power-good per supply
   input wire logic slow_tick,                      // 31,250 Hz tick, one cycle
   input wire logic wake_pin,                       // External wake pin
   input wire logic sleep_req,                      // Sleep request pulse
   input wire sws_pkg::sws_sleep_cfg_t sleep_cfg,   // Sleep configuration
   input wire logic [63:0] wake_compare,            // Counter wake value
   input wire logic [31:0] slow_increment,          // Added per slow tick
   input wire logic wdog_en,                        // Watchdog enable
   input wire logic [15:0] wdog_timeout_ms,         // Timeout in ms
   input wire logic wdog_reload,                    // Reload pulse
   input wire logic cause_clear,                    // Clear reset cause
   input wire sws_pkg::sws_ret_req_t ret_req,       // Retention access
   output logic [7:0] ret_rdata,                    // Retention read data
   output sws_pkg::sws_state_t power_state,         // Current power state
   output logic [63:0] rtc_count,                   // Real-time counter
   output logic [15:0] wdog_count,                  // Watchdog ms count
   output logic wdog_reset_cause,                   // Last reset by watchdog
   output logic sys_reset_n,                        // Chip reset, active low
   output sws_pkg::sws_pwr_ctl_t pwr_ctl            // Domain controls
);
   import sws_pkg::*;

   sws_state_t state;
   logic all_good;
   logic wdog_fire;
   logic wake_pending;
   logic wake_now;
   logic pin_hit;
   logic timer_hit;
   logic [15:0] trans_cnt;
   logic [16:0] ms_cnt;
   logic wdog_run;
   logic supply_fault;

   // Count of transition cycles at a fixed budget
   function automatic logic trans_done(input logic [15:0] cnt);
      trans_done = (cnt == (`SWS_TRANS_CYCLES - 16'h0001));
   endfunction

   assign all_good = (supply_good == `SWS_SUPPLY_ALL_GOOD);
   // Fault in any state other than POR forces a full restart
   assign supply_fault = !all_good;

   // Stimulus sources, evaluated in every state but latched only on the way down
   assign pin_hit = sleep_cfg.wake_pin_en && (wake_pin == sleep_cfg.wake_pin_level);
   assign timer_hit = sleep_cfg.wake_timer_en && (rtc_count >= wake_compare);
   assign wake_now = pin_hit || timer_hit || wake_pending;

   // Main power sequencer; supply faults win over everything
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         state <= SWS_ST_POR;
      else if (supply_fault)
         state <= SWS_ST_POR;
      else if (wdog_fire)
         state <= SWS_ST_POR;
      else
      begin
         unique case (state)
            SWS_ST_POR:
               state <= SWS_ST_AWAKE;
            SWS_ST_AWAKE:
               if (sleep_req)
                  state <= SWS_ST_TO_SLEEP;
            SWS_ST_TO_SLEEP:
               if (trans_done(trans_cnt))
                  state <= SWS_ST_ASLEEP;
            SWS_ST_ASLEEP:
               if (wake_now)
                  state <= SWS_ST_TO_WAKE;
            SWS_ST_TO_WAKE:
               if (trans_done(trans_cnt))
                  state <= SWS_ST_AWAKE;
         endcase
      end
   end

   // Transition timer, restarted on every state change
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         trans_cnt <= `SWS_TRANS_RESET;
      else if (state == SWS_ST_TO_SLEEP || state == SWS_ST_TO_WAKE)
         trans_cnt <= trans_done(trans_cnt) ? `SWS_TRANS_RESET : trans_cnt + 16'h0001;
      else
         trans_cnt <= `SWS_TRANS_RESET;
   end

   // A stimulus seen during sleep entry is held until asleep; ignored when awake
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         wake_pending <= 1'b0;
      else if (state == SWS_ST_TO_SLEEP && (pin_hit || timer_hit))
         wake_pending <= 1'b1;
      else if (state != SWS_ST_TO_SLEEP && state != SWS_ST_ASLEEP)
         wake_pending <= 1'b0;
      else if (state == SWS_ST_ASLEEP)
         wake_pending <= 1'b0;
   end

   // Real-time counter: per clock awake, increment per slow tick when selected
   // Kept on clk_sys so it stays cycle-locked with the processor timers
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n || state == SWS_ST_POR)
         rtc_count <= `SWS_RTC_RESET;
      else if (state == SWS_ST_ASLEEP && sleep_cfg.slow_osc_sel)
      begin
         if (slow_tick)
            rtc_count <= rtc_count + {32'h00000000, slow_increment};
      end
      else
         rtc_count <= rtc_count + 64'h0000000000000001;
   end

   // Watchdog enabled only while awake; own prescaler, no shared count
   assign wdog_run = wdog_en && (state == SWS_ST_AWAKE);

   // Millisecond prescaler
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n || !wdog_run || wdog_reload)
         ms_cnt <= `SWS_MS_RESET;
      else if (ms_cnt == 17'(`SWS_MS_CYCLES - 1))
         ms_cnt <= `SWS_MS_RESET;
      else
         ms_cnt <= ms_cnt + 17'h00001;
   end

   // Watchdog counts elapsed milliseconds toward the programmed timeout
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n || !wdog_run || wdog_reload)
         wdog_count <= `SWS_WDOG_RESET;
      else if (ms_cnt == 17'(`SWS_MS_CYCLES - 1))
         wdog_count <= wdog_count + 16'h0001;
   end

   // Expiry when the elapsed count reaches the timeout (minimum 1 ms)
   assign wdog_fire = wdog_run && !wdog_reload && (wdog_timeout_ms != 16'h0000)
                      && (wdog_count >= wdog_timeout_ms);

   // Reset cause survives the watchdog reset; cleared by power loss or software
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n || supply_fault)
         wdog_reset_cause <= 1'b0;
      else if (wdog_fire)
         wdog_reset_cause <= 1'b1;
      else if (cause_clear)
         wdog_reset_cause <= 1'b0;
   end

   // Chip reset held in POR and while any supply is bad
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         sys_reset_n <= 1'b0;
      else
         sys_reset_n <= all_good && !wdog_fire && (state != SWS_ST_POR);
   end

   // Domain controls; the low-power choice is software's to program
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         pwr_ctl <= '0;
      else if (state == SWS_ST_ASLEEP)
      begin
         pwr_ctl.digital_pwr_en <= 1'b0;
         pwr_ctl.digital_clk_en <= !sleep_cfg.clock_mask;
         pwr_ctl.digital_rst_n <= !sleep_cfg.assert_reset;
         pwr_ctl.supply_other_en <= !sleep_cfg.supplies_off;
         pwr_ctl.second_buck_supply_en <= 1'b1;
         pwr_ctl.pulse_frequency_mode <= sleep_cfg.pulse_frequency_mode;
      end
      else
      begin
         pwr_ctl.digital_pwr_en <= (state != SWS_ST_POR);
         pwr_ctl.digital_clk_en <= (state != SWS_ST_POR);
         pwr_ctl.digital_rst_n <= (state == SWS_ST_AWAKE);
         pwr_ctl.supply_other_en <= 1'b1;
         pwr_ctl.second_buck_supply_en <= 1'b1;
         pwr_ctl.pulse_frequency_mode <= 1'b0;
      end
   end

   assign power_state = state;

   // Retention store sits on the always-on domain, powered while supplies hold
   sws_retention_mem u_ret
   (
      .clk_sys(clk_sys),
      .aon_alive(all_good),
      .req(ret_req),
      .rdata(ret_rdata)
   );

   // Checks
   sequence s_enter_sleep;
      state == SWS_ST_TO_SLEEP ##1 state == SWS_ST_ASLEEP;
   endsequence

   property p_pin_wake;
      @(posedge clk_sys) disable iff (!reset_n)
      (state == SWS_ST_ASLEEP && pin_hit && all_good && !wdog_fire)
      |=> state == SWS_ST_TO_WAKE;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake missed");

   property p_timer_wake;
      @(posedge clk_sys) disable iff (!reset_n)
      (state == SWS_ST_ASLEEP && timer_hit && all_good) |=> state == SWS_ST_TO_WAKE;
   endproperty
   a_timer_wake: assert property (p_timer_wake) else $error("timer wake missed");

   property p_awake_ignores;
      @(posedge clk_sys) disable iff (!reset_n)
      (state == SWS_ST_AWAKE && !sleep_req && all_good && !wdog_fire)
      |=> state == SWS_ST_AWAKE;
   endproperty
   a_awake_ignores: assert property (p_awake_ignores) else $error("woke while awake");

   property p_pending_wake;
      @(posedge clk_sys) disable iff (!reset_n || !all_good)
      (state == SWS_ST_TO_SLEEP && pin_hit) ##0 s_enter_sleep ##1 all_good
      |-> state == SWS_ST_TO_WAKE;
   endproperty
   a_pending_wake: assert property (p_pending_wake) else $error("pending wake lost");

   property p_sleep_power;
      @(posedge clk_sys) disable iff (!reset_n)
      s_enter_sleep |=> !pwr_ctl.digital_pwr_en && pwr_ctl.second_buck_supply_en;
   endproperty
   a_sleep_power: assert property (p_sleep_power) else $error("node not down");

   property p_rtc_tick;
      @(posedge clk_sys) disable iff (!reset_n)
      (state == SWS_ST_AWAKE && $past(state) == SWS_ST_AWAKE)
      |-> rtc_count == $past(rtc_count) + 64'h0000000000000001;
   endproperty
   a_rtc_tick: assert property (p_rtc_tick) else $error("rtc not ticking");

   property p_wdog_stop;
      @(posedge clk_sys) disable iff (!reset_n)
      (state != SWS_ST_AWAKE) |=> wdog_count == `SWS_WDOG_RESET;
   endproperty
   a_wdog_stop: assert property (p_wdog_stop) else $error("wdog ran asleep");

   property p_wdog_reset;
      @(posedge clk_sys) disable iff (!reset_n)
      wdog_fire |=> !sys_reset_n && wdog_reset_cause;
   endproperty
   a_wdog_reset: assert property (p_wdog_reset) else $error("no wdog reset");

   property p_supply_reset;
      @(posedge clk_sys) disable iff (!reset_n)
      !all_good |=> !sys_reset_n ##0 state == SWS_ST_POR;
   endproperty
   a_supply_reset: assert property (p_supply_reset) else $error("no supply reset");

   // A healthy sleep request always starts the way down
   property p_sleep_take;
      @(posedge clk_sys) disable iff (!reset_n)
      (state == SWS_ST_AWAKE && sleep_req && all_good && !wdog_fire)
      |=> state == SWS_ST_TO_SLEEP;
   endproperty
   a_sleep_take: assert property (p_sleep_take) else $error("sleep request lost");

   // Running state never jumps straight into sleep or wake
   property p_no_early_wake;
      @(posedge clk_sys) disable iff (!reset_n)
      state == SWS_ST_AWAKE
      |=> state != SWS_ST_TO_WAKE && state != SWS_ST_ASLEEP;
   endproperty
   a_no_early_wake: assert property (p_no_early_wake) else $error("awake skipped entry");

   // Each slow tick adds exactly the programmed step
   property p_slow_add;
      @(posedge clk_sys) disable iff (!reset_n)
      (state == SWS_ST_ASLEEP && sleep_cfg.slow_osc_sel && slow_tick)
      |=> rtc_count == $past(rtc_count) + {32'h00000000, $past(slow_increment)};
   endproperty
   a_slow_add: assert property (p_slow_add) else $error("slow step wrong");

   // Between slow ticks the counter must not move on the fast clock
   property p_slow_hold;
      @(posedge clk_sys) disable iff (!reset_n)
      (state == SWS_ST_ASLEEP && sleep_cfg.slow_osc_sel && !slow_tick)
      |=> rtc_count == $past(rtc_count);
   endproperty
   a_slow_hold: assert property (p_slow_hold) else $error("counter ran fast");

   // Elapsed count at the timeout restarts the chip
   property p_wdog_expire;
      @(posedge clk_sys) disable iff (!reset_n)
      (wdog_run && !wdog_reload && wdog_timeout_ms != 16'h0000 && wdog_count == wdog_timeout_ms)
      |=> state == SWS_ST_POR;
   endproperty
   a_wdog_expire: assert property (p_wdog_expire) else $error("wdog did not expire");

   // The cause survives the restart it reports
   property p_cause_hold;
      @(posedge clk_sys) disable iff (!reset_n)
      (wdog_reset_cause && !cause_clear && all_good) |=> wdog_reset_cause;
   endproperty
   a_cause_hold: assert property (p_cause_hold) else $error("reset cause lost");

   // Power-on state always keeps the chip in reset
   property p_por_reset;
      @(posedge clk_sys) disable iff (!reset_n)
      state == SWS_ST_POR |=> !sys_reset_n;
   endproperty
   a_por_reset: assert property (p_por_reset) else $error("reset released early");

   // Wake-up transition still running at its 9th of 16 cycles when supplies hold
   sequence s_wake_start;
      state == SWS_ST_ASLEEP ##1 state == SWS_ST_TO_WAKE;
   endsequence

   property p_wake_len;
      @(posedge clk_sys) disable iff (!reset_n)
      s_wake_start ##1 all_good [*8] |-> state == SWS_ST_TO_WAKE;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake cut short");
endmodule // sleep_wake_supervisor

// *** dv/sws_partner.sv ***
`timescale 1ns/1ps
// Far side: slow oscillator tick source and the external wake pin
module sws_partner
#(
   parameter int TICK_DIV = 20  // Shortened slow-tick spacing
)
(
   input wire logic clk_sys,    // System clock
   input wire logic pin_cmd,    // Level the bench wants on the pin
   output logic slow_tick,      // One-cycle slow tick
   output logic wake_pin        // Wake pin, synchronous
);
   int cnt = 0;
   initial slow_tick = 1'b0;
   initial wake_pin = 1'b0;
   // Free-running tick; real oscillator never stops, so neither does this
   always_ff @(posedge clk_sys)
   begin
      cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      slow_tick <= (cnt == TICK_DIV - 1);
   end
   // Pin follows the command one cycle late, like a pad register
   always_ff @(posedge clk_sys)
   begin
      wake_pin <= pin_cmd;
   end
endmodule // sws_partner

// *** dv/sleep_wake_supervisor_test.sv ***
`timescale 1ns/1ps
module sleep_wake_supervisor_test;
   import sws_pkg::*;
   localparam int TD = 20;
   logic clk_sys = 1'b0, reset_n = 1'b0, sleep_req = 1'b0, pin_cmd = 1'b0;
   logic wdog_en = 1'b0, wdog_reload = 1'b0, cause_clear = 1'b0;
   logic [2:0] supply_good = 3'h7;
   sws_sleep_cfg_t sleep_cfg = '0;
   logic [63:0] wake_compare = 64'hFFFFFFFFFFFFFFFF;
   logic [31:0] slow_increment = 32'h00000000;
   logic [15:0] wdog_timeout_ms = 16'h0000;
   sws_ret_req_t ret_req = '0;
   logic slow_tick, wake_pin, wdog_reset_cause, sys_reset_n;
   logic [7:0] ret_rdata;
   logic [15:0] wdog_count;
   logic [63:0] rtc_count, r0;
   sws_state_t power_state;
   sws_pwr_ctl_t pwr_ctl;
   int num_errors = 0, compares = 0, seed = 32'h5f34;
   logic [7:0] mem [4];
   // Low-power sleep settings plus chosen wake sources
   sws_sleep_cfg_t lp = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

   sws_partner #(.TICK_DIV(TD)) u_far (.clk_sys(clk_sys), .pin_cmd(pin_cmd),
      .slow_tick(slow_tick), .wake_pin(wake_pin));
   sleep_wake_supervisor u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .supply_good(supply_good), .slow_tick(slow_tick), .wake_pin(wake_pin),
      .sleep_req(sleep_req), .sleep_cfg(sleep_cfg), .wake_compare(wake_compare),
      .slow_increment(slow_increment), .wdog_en(wdog_en),
      .wdog_timeout_ms(wdog_timeout_ms), .wdog_reload(wdog_reload),
      .cause_clear(cause_clear), .ret_req(ret_req), .ret_rdata(ret_rdata),
      .power_state(power_state), .rtc_count(rtc_count), .wdog_count(wdog_count),
      .wdog_reset_cause(wdog_reset_cause), .sys_reset_n(sys_reset_n),
      .pwr_ctl(pwr_ctl));

   // 100 MHz clock
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk_v(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_st(input sws_state_t e);
      chk_v({61'h0, power_state}, {61'h0, e});
   endtask
   // Bounded wait; a hang here is a mismatch, not a stall
   task automatic wait_st(input sws_state_t s);
      int i;
      for (i = 0; i < 200 && power_state !== s; i++) cyc(1);
      chk_st(s);
   endtask
   task automatic go_sleep(input sws_sleep_cfg_t c);
      sleep_cfg = c;
      sleep_req = 1'b1;
      cyc(1);
      sleep_req = 1'b0;
   endtask
   task automatic report_and_stop;
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Watchdog on the whole run, sized for the long watchdog test
   initial
   begin
      #1500000;
      num_errors++;
      report_and_stop;
   end

   initial
   begin
      cyc(6);
      reset_n = 1'b1;
      cyc(3);
      chk_v(sys_reset_n, 1'b1);
      supply_good = 3'h6;
      cyc(3);
      chk_v(sys_reset_n, 1'b0);
      chk_st(SWS_ST_POR);
      supply_good = 3'h7;
      wait_st(SWS_ST_AWAKE);
      cyc(2);
      chk_v(sys_reset_n, 1'b1);
      r0 = rtc_count;
      cyc(10);
      chk_v(rtc_count, r0 + 64'h000000000000000A);
      $display("test reset done");
      // Random bytes into retention memory
      for (int i = 0; i < 4; i++)
      begin
         mem[i] = $random(seed);
         ret_req = '{1'b1, 7'(i * 37 + 5), mem[i]};
         cyc(1);
      end
      ret_req.we = 1'b0;
      sleep_cfg = lp;
      pin_cmd = 1'b1;
      cyc(20);
      chk_st(SWS_ST_AWAKE);
      pin_cmd = 1'b0;
      cyc(2);
      go_sleep(lp);
      chk_st(SWS_ST_TO_SLEEP);
      cyc(4);
      pin_cmd = 1'b1;
      cyc(1);
      pin_cmd = 1'b0;
      wait_st(SWS_ST_ASLEEP);
      cyc(1);
      chk_st(SWS_ST_TO_WAKE);
      wait_st(SWS_ST_AWAKE);
      $display("test latched wake done");
      pin_cmd = 1'b1;
      cyc(2);
      lp.wake_pin_level = 1'b0;
      go_sleep(lp);
      wait_st(SWS_ST_ASLEEP);
      cyc(30);
      chk_st(SWS_ST_ASLEEP);
      chk_v(pwr_ctl.digital_pwr_en, 1'b0);
      chk_v(pwr_ctl, 6'h03);
      pin_cmd = 1'b0;
      cyc(3);
      chk_st(SWS_ST_TO_WAKE);
      wait_st(SWS_ST_AWAKE);
      for (int i = 0; i < 4; i++)
      begin
         ret_req.addr = 7'(i * 37 + 5);
         cyc(2);
         chk_v(ret_rdata, mem[i]);
      end
      $display("test pin wake done");
      slow_increment = ($random(seed) & 32'h0FFFFFFF) | 32'h1;
      wake_compare = rtc_count + 64'h100000000;
      go_sleep('{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1});
      wait_st(SWS_ST_ASLEEP);
      r0 = rtc_count;
      cyc(TD);
      chk_v(rtc_count, r0 + {32'h0, slow_increment});
      wake_compare = r0 + 3 * {32'h0, slow_increment};
      wait_st(SWS_ST_TO_WAKE);
      wait_st(SWS_ST_AWAKE);
      $display("test timer wake done");
      go_sleep(lp);
      cyc(4);
      supply_good = 3'h5;
      cyc(2);
      chk_v(sys_reset_n, 1'b0);
      supply_good = 3'h7;
      wait_st(SWS_ST_AWAKE);
      cyc(2);
      $display("test transition fault done");
      wdog_timeout_ms = 16'h0001;
      wdog_en = 1'b1;
      cyc(99990);
      chk_v(sys_reset_n, 1'b1);
      chk_v(wdog_count, 16'h0000);
      wait_st(SWS_ST_POR);
      wdog_en = 1'b0;
      wait_st(SWS_ST_AWAKE);
      cyc(2);
      chk_v(wdog_reset_cause, 1'b1);
      cause_clear = 1'b1;
      cyc(1);
      cause_clear = 1'b0;
      cyc(1);
      chk_v(wdog_reset_cause, 1'b0);
      $display("test watchdog done");
      report_and_stop;
   end
endmodule // sleep_wake_supervisor_test
